// File: src/smacr_defs.svh
// Field positions, reset value and timing counts for the config register
`ifndef SMACR_DEFS_SVH
`define SMACR_DEFS_SVH
`define SMACR_RESET_VAL 16'hAA90
`define SMACR_POS_UV_MSB 15
`define SMACR_POS_UV_LSB 14
`define SMACR_POS_OV_MSB 13
`define SMACR_POS_OV_LSB 12
`define SMACR_NEG_UV_MSB 11
`define SMACR_NEG_UV_LSB 10
`define SMACR_NEG_OV_MSB 9
`define SMACR_NEG_OV_LSB 8
`define SMACR_ADC_EN_BIT 7
`define SMACR_MODE_MSB 6
`define SMACR_MODE_LSB 5
`define SMACR_DLY_MSB 4
`define SMACR_DLY_LSB 3
`define SMACR_FLT_RPT_BIT 2
`define SMACR_FSS_MSB 1
`define SMACR_FSS_LSB 0
`define SMACR_CLK_PERIOD_PS 8000
`define SMACR_DLY_STEP_NS 280
`define SMACR_DLY_STEP_CYC ((`SMACR_DLY_STEP_NS * 1000 + \
  `SMACR_CLK_PERIOD_PS - 1) / `SMACR_CLK_PERIOD_PS)
`endif

// File: src/smacr_pkg.sv
// Types for the supply lockout and converter configuration register
package smacr_pkg;
  typedef enum logic [1:0] {
    SMACR_ALIGN_CENTER = 2'h0,
    SMACR_ALIGN_EDGE = 2'h1,
    SMACR_ALIGN_HYBRID = 2'h2,
    SMACR_ALIGN_RSVD = 2'h3
  } smacr_align_t;
  typedef enum logic [1:0] {
    SMACR_FS_LOW = 2'h0,
    SMACR_FS_HIGH = 2'h1,
    SMACR_FS_HIZ = 2'h2,
    SMACR_FS_NONE = 2'h3
  } smacr_fs_t;
  typedef struct packed {
    logic [1:0] pos_supply_undervolt_threshold;
    logic [1:0] pos_supply_overvolt_threshold;
    logic [1:0] neg_supply_undervolt_threshold;
    logic [1:0] neg_supply_overvolt_threshold;
    logic converter_sampling_enable;
    smacr_align_t converter_sampling_alignment;
    logic [1:0] converter_sample_point_delay;
    logic converter_fault_report_enable;
    smacr_fs_t converter_fault_output_state;
  } smacr_cfg_t;
  typedef struct packed {
    logic source_drive_o;
    logic source_oe_b;
    logic sink_drive_o;
    logic sink_oe_b;
  } smacr_gate_t;
endpackage

// File: src/smacr_cfg_store.sv
// Sixteen-bit configuration storage with registered read data
`timescale 1ns/1ps
`include "smacr_defs.svh"
module smacr_cfg_store
  import smacr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic wr_en_i,
  input wire logic [15:0] wr_data_i,
  output smacr_cfg_t cfg_o,
  output logic [15:0] rd_data_o
);
  logic [15:0] cfg_q;
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      cfg_q <= `SMACR_RESET_VAL;
    else if (wr_en_i)
      cfg_q <= wr_data_i;
  end
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rd_data_o <= `SMACR_RESET_VAL;
    else if (wr_en_i)
      rd_data_o <= wr_data_i;
  end
  assign cfg_o = smacr_cfg_t'(cfg_q);
endmodule // smacr_cfg_store

// File: src/smacr_top.sv
// Supply lockout thresholds and converter sampling/fault configuration
// Functional notes
// - Positive supply undervoltage code, bits 15-14, reset 2
// - Positive supply overvoltage code, bits 13-12, reset 2
// - Negative supply undervoltage code, bits 11-10, reset 2
// - Negative supply overvoltage code, bits 9-8, reset 2
// - Bit 7 enables sampling; bits 6-5 alignment, 3 reserved
// - Bits 4-3 set sample delay 280 to 1120 ns
// - Bit 2 routes converter fault to alarm output
// - Bits 1-0 force gate outputs during converter fault
`timescale 1ns/1ps
`include "smacr_defs.svh"
module smacr_top
  import smacr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic cfg_wr_i,
  input wire logic [15:0] cfg_wdata_i,
  output logic [15:0] cfg_rdata_o,
  input wire logic pwm_in_i,
  input wire logic conv_fault_i,
  output logic primary_fault_alarm_out_b_o,
  output smacr_gate_t gate_o,
  output logic conv_sample_o,
  output logic [1:0] pos_supply_undervolt_threshold_o,
  output logic [1:0] pos_supply_overvolt_threshold_o,
  output logic [1:0] neg_supply_undervolt_threshold_o,
  output logic [1:0] neg_supply_overvolt_threshold_o,
  output logic [1:0] converter_sampling_alignment_o
);
  import smacr_pkg::*;
  localparam int STEP = `SMACR_DLY_STEP_CYC;
  smacr_cfg_t cfg;
  logic [15:0] rdata;
  logic [1:0] pwm_sync_q;
  logic [1:0] flt_sync_q;
  logic pwm_prev_q;
  logic [8:0] dly_cnt_q;
  logic dly_run_q;
  logic [8:0] dly_target;

  smacr_cfg_store u_store (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .wr_en_i(cfg_wr_i),
    .wr_data_i(cfg_wdata_i),
    .cfg_o(cfg),
    .rd_data_o(rdata)
  );

  // Pin inputs are asynchronous; two stages before any logic looks at them
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pwm_sync_q <= 2'h0;
      flt_sync_q <= 2'h0;
      pwm_prev_q <= 1'b0;
    end
    else
    begin
      pwm_sync_q <= {pwm_sync_q[0], pwm_in_i};
      flt_sync_q <= {flt_sync_q[0], conv_fault_i};
      pwm_prev_q <= pwm_sync_q[1];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      cfg_rdata_o <= `SMACR_RESET_VAL;
    else
      cfg_rdata_o <= cfg_wr_i ? cfg_wdata_i : rdata;
  end

  // Threshold codes pass one register on the way to the analog comparators
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pos_supply_undervolt_threshold_o <= 2'h2;
      pos_supply_overvolt_threshold_o <= 2'h2;
      neg_supply_undervolt_threshold_o <= 2'h2;
      neg_supply_overvolt_threshold_o <= 2'h2;
      converter_sampling_alignment_o <= 2'h0;
    end
    else
    begin
      pos_supply_undervolt_threshold_o <=
        cfg.pos_supply_undervolt_threshold;
      pos_supply_overvolt_threshold_o <=
        cfg.pos_supply_overvolt_threshold;
      neg_supply_undervolt_threshold_o <=
        cfg.neg_supply_undervolt_threshold;
      neg_supply_overvolt_threshold_o <=
        cfg.neg_supply_overvolt_threshold;
      // Reserved code is passed through; software must not write it
      converter_sampling_alignment_o <=
        cfg.converter_sampling_alignment;
    end
  end

  // Delay counts whole cycles rounded up: 35 cycles per 280 ns step
  assign dly_target = 9'(STEP * (int'(cfg.converter_sample_point_delay)
    + 1));

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      dly_cnt_q <= 9'h000;
      dly_run_q <= 1'b0;
      conv_sample_o <= 1'b0;
    end
    else
    begin
      conv_sample_o <= 1'b0;
      if (!cfg.converter_sampling_enable)
      begin
        dly_run_q <= 1'b0;
        dly_cnt_q <= 9'h000;
      end
      else if (pwm_sync_q[1] && !pwm_prev_q)
      begin
        dly_run_q <= 1'b1;
        dly_cnt_q <= 9'h001;
      end
      else if (dly_run_q)
      begin
        if (dly_cnt_q >= dly_target)
        begin
          dly_run_q <= 1'b0;
          conv_sample_o <= 1'b1;
        end
        else
          dly_cnt_q <= dly_cnt_q + 9'h001;
      end
    end
  end

  // Alarm pin is active low
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      primary_fault_alarm_out_b_o <= 1'b1;
    else
      primary_fault_alarm_out_b_o <=
        !(flt_sync_q[1] && cfg.converter_fault_report_enable);
  end

  // Fault overrides gate drive; enables are low while driving
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      gate_o <= '{1'b0, 1'b1, 1'b0, 1'b1};
    else if (!flt_sync_q[1])
      gate_o <= '{1'b0, 1'b1, 1'b0, 1'b1};
    else
    begin
      case (cfg.converter_fault_output_state)
        SMACR_FS_LOW: gate_o <= '{1'b0, 1'b1, 1'b0, 1'b0};
        SMACR_FS_HIGH: gate_o <= '{1'b1, 1'b0, 1'b0, 1'b1};
        SMACR_FS_HIZ: gate_o <= '{1'b0, 1'b1, 1'b0, 1'b1};
        default: gate_o <= '{1'b0, 1'b1, 1'b0, 1'b1};
      endcase
    end
  end
endmodule // smacr_top

// File: tb/smacr_checker.sv
// Checker for the config register ports
`timescale 1ns/1ps
module smacr_checker
  import smacr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic cfg_wr_i,
  input wire logic [15:0] cfg_wdata_i,
  input wire logic [15:0] cfg_rdata_o,
  input wire logic conv_fault_i,
  input wire logic primary_fault_alarm_out_b_o,
  input wire smacr_pkg::smacr_gate_t gate_o,
  input wire logic conv_sample_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  // Fault passes two sync flops and a register, so four samples
  wire [15:0] r = cfg_rdata_o;
  wire a = primary_fault_alarm_out_b_o;
  wire f = conv_fault_i;
  property p_wr; cfg_wr_i |=> r == $past(cfg_wdata_i); endproperty
  a_wr: assert property (p_wr) else $error("readback");
  property p_one; conv_sample_o |=> !conv_sample_o; endproperty
  a_one: assert property (p_one) else $error("long pulse");
  property p_en; (!r[7]) [*4] |-> !conv_sample_o; endproperty
  a_en: assert property (p_en) else $error("sample off");
  property p_rpt; (f && r[2]) [*4] |-> !a; endproperty
  a_rpt: assert property (p_rpt) else $error("no alarm");
  property p_msk; (!r[2]) [*3] |-> a; endproperty
  a_msk: assert property (p_msk) else $error("masked alarm");
  property p_lo; (f && r[1:0] == 2'h0) [*4] |-> gate_o == 4'h4; endproperty
  a_lo: assert property (p_lo) else $error("pull low");
  property p_hi; (f && r[1:0] == 2'h1) [*4] |-> gate_o == 4'h9; endproperty
  a_hi: assert property (p_hi) else $error("pull high");
  property p_rel; (!f || r[1]) [*4] |-> gate_o == 4'h5; endproperty
  a_rel: assert property (p_rel) else $error("release");
endmodule // smacr_checker
bind smacr_top smacr_checker u_chk (.*);

// File: tb/smacr_host.sv
// Host model issuing whole-word config writes
`timescale 1ns/1ps
module smacr_host (
  input wire logic core_clk_i,
  output logic cfg_wr_o,
  output logic [15:0] cfg_wdata_o
);
  initial {cfg_wr_o, cfg_wdata_o} = 17'h00000;
  task put(input logic [15:0] d);
    @(posedge core_clk_i);
    #1 {cfg_wr_o, cfg_wdata_o} = {1'b1, d};
    @(posedge core_clk_i);
    // Stale data inverted so a late sample never looks valid
    #1 {cfg_wr_o, cfg_wdata_o} = {1'b0, ~d};
  endtask
endmodule // smacr_host

// File: tb/smacr_top_test.sv
// Bench for the config register
`timescale 1ns/1ps
module smacr_top_test;
  import smacr_pkg::*;
  logic clk = 0, rst_b = 0, wr, pwm = 0, flt = 0, al, smp;
  logic [15:0] wd, rd;
  logic [7:0] th;
  logic [1:0] alg;
  smacr_gate_t g;
  int miscompares = 0, comparisons = 0, n;
  // Row: word, {read, 6'h0, thresholds, align}, {alarm, gate, delay/35}
  logic [39:0] row [4] = '{40'h0084000021, 40'h55AD01554A,
    40'hAAD602AA2B, 40'hFF9F03FC2C};
  smacr_top dut (.core_clk_i(clk), .rst_b_i(rst_b), .cfg_wr_i(wr),
    .cfg_wdata_i(wd), .cfg_rdata_o(rd), .pwm_in_i(pwm), .conv_fault_i(flt),
    .primary_fault_alarm_out_b_o(al), .gate_o(g), .conv_sample_o(smp),
    .pos_supply_undervolt_threshold_o(th[7:6]),
    .pos_supply_overvolt_threshold_o(th[5:4]),
    .neg_supply_undervolt_threshold_o(th[3:2]),
    .neg_supply_overvolt_threshold_o(th[1:0]),
    .converter_sampling_alignment_o(alg));
  smacr_host u_host (.core_clk_i(clk), .cfg_wr_o(wr), .cfg_wdata_o(wd));
  always #4 clk = ~clk;
  task cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task chk(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    cyc(12);
    chk({rd, th, alg, g, al, smp}, 32'hAA90AA16);
    rst_b = 1;
    $display("reset test done");
    foreach (row[i])
    begin
      u_host.put(row[i][39:24]);
      cyc(2);
      chk({rd, 6'h00, th, alg}, row[i][39:8]);
      pwm = 1;
      for (n = 0; !smp && n < 200; n++)
        cyc(1);
      pwm = 0;
      flt = 1;
      cyc(4);
      chk(32'({al, g, 3'(n / 35)}), 32'(row[i][7:0]));
      flt = 0;
      if (n == 200)
      begin
        miscompares++;
        wrap_up;
      end
    end
    $display("table test done");
    // Sampling off and alarm masked: no pulse, alarm stays high
    u_host.put(16'hAA10);
    cyc(2);
    chk(32'(rd), 32'h0000AA10);
    pwm = 1;
    flt = 1;
    n = 0;
    repeat (120)
    begin
      cyc(1);
      n += int'(smp);
    end
    chk(32'({al, g, n[7:0]}), 32'h00001400);
    pwm = 0;
    flt = 0;
    cyc(4);
    $display("disable test done");
    flt = 1;
    cyc(4);
    rst_b = 0;
    cyc(1);
    chk({rd, th, alg, g, al, smp}, 32'hAA90AA16);
    $display("mid-run reset test done");
    wrap_up;
  end
endmodule // smacr_top_test
